/* src/wclk_defines.svh */
`ifndef WCLK_DEFINES_SVH
`define WCLK_DEFINES_SVH

// System clock
`define CLK_HZ           50000000
`define CLK_PERIOD_NS    20

// Accepted external word clock range
`define FS_MIN_HZ        32000
`define FS_MAX_HZ        192000
`define PER_MIN_CYC      (`CLK_HZ / `FS_MAX_HZ)
`define PER_MAX_CYC      ((`CLK_HZ + `FS_MIN_HZ - 1) / `FS_MIN_HZ)

// Loss of external clock
`define LOST_TIMEOUT_NS  100000
`define LOST_TIMEOUT_CYC ((`LOST_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Rate select codes
`define RATE_32K         4'h0
`define RATE_44K1        4'h1
`define RATE_47K952      4'h2
`define RATE_48K         4'h3
`define RATE_48K048      4'h4
`define RATE_88K2        4'h5
`define RATE_96K         4'h6
`define RATE_96K096      4'h7
`define RATE_176K4       4'h8
`define RATE_192K        4'h9

// Phase increments: fs * 2^32 / CLK_HZ
`define INC_32K          32'h0029F16B
`define INC_44K1         32'h0039CD81
`define INC_47K952       32'h003EDA05
`define INC_48K          32'h003EEA21
`define INC_48K048       32'h003EFA3C
`define INC_88K2         32'h00739B02
`define INC_96K          32'h007DD441
`define INC_96K096       32'h007DF478
`define INC_176K4        32'h00E73605
`define INC_192K         32'h00FBA882

`endif

/* src/wclk_pkg.sv */
package wclk_pkg;

  typedef enum logic [1:0] {
    SRC_INT  = 2'h0,
    SRC_WORD = 2'h1,
    SRC_AES  = 2'h2,
    SRC_LINK = 2'h3
  } clk_src_type;

  typedef enum logic [1:0] {
    SW_RUN   = 2'b00,
    SW_DRAIN = 2'b01,
    SW_ARM   = 2'b11
  } sw_state_type;

endpackage

/* src/bit_sync.sv */
`timescale 1ns/1ps

module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Data
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_r;

  // Only the second stage is read outside this module
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= '0;
      o_q    <= '0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end

endmodule // bit_sync

/* src/wclk_link_ctrl.sv */
`timescale 1ns/1ps
`include "wclk_defines.svh"

module wclk_link_ctrl #(
  parameter int CNT_W    = 16,
  parameter int LOST_CYC = `LOST_TIMEOUT_CYC,
  parameter int PER_MIN  = `PER_MIN_CYC,
  parameter int PER_MAX  = `PER_MAX_CYC
) (
  // Clocks and reset
  input  wire logic       I_CLK,
  input  wire logic       I_SRST,
  input  wire logic       I_LINK_CLK,
  // Local control
  input  wire logic [3:0] I_RATE_SEL,
  input  wire logic [1:0] I_SRC_REQ,
  input  wire logic       I_PLAY,
  input  wire logic       I_REC_START,
  input  wire logic       I_REC_STOP,
  input  wire logic       I_TC,
  input  wire logic       I_TXD,
  // External clock pins
  input  wire logic       I_WCLK,
  input  wire logic       I_AES_FCLK,
  // Link input side
  input  wire logic       I_LINK_IN_CONN,
  input  wire logic       I_LINK_OUT_CONN,
  input  wire logic       I_LINK_WCLK,
  input  wire logic       I_LINK_REC,
  input  wire logic       I_LINK_TC,
  input  wire logic       I_LINK_RXD,
  // Clock, link and record status, received time code and data
  output logic            O_WCLK,
  output logic [1:0]      O_CLK_SRC,
  output logic            O_EXT_LOST,
  output logic            O_RATE_OK,
  output logic            O_LINK_MASTER,
  output logic            O_LINK_SLAVE,
  output logic            O_REC,
  output logic            O_TC_RX,
  output logic            O_RXD,
  // Link output side
  output logic            O_LINK_WCLK,
  output logic            O_LINK_REC,
  output logic            O_LINK_TC,
  output logic            O_LINK_TXD
);

  localparam logic [CNT_W-1:0] LOST_LIM = CNT_W'(LOST_CYC - 1);
  localparam logic [CNT_W-1:0] PER_LO   = CNT_W'(PER_MIN - 1);
  localparam logic [CNT_W-1:0] PER_HI   = CNT_W'(PER_MAX - 1);

  // Link clock domain
  logic       link_rst;
  logic       lrec_s;
  logic       lrec_prev_r;
  logic       start_tgl_r;
  logic       stop_tgl_r;

  bit_sync #(.WIDTH(1)) u_link_rst (
    .i_clk (I_LINK_CLK),
    .i_rst (1'b0),
    .i_d   (I_SRST),
    .o_q   (link_rst)
  );

  bit_sync #(.WIDTH(1)) u_link_rec (
    .i_clk (I_LINK_CLK),
    .i_rst (link_rst),
    .i_d   (I_LINK_REC),
    .o_q   (lrec_s)
  );

  // Upstream record level turned into start and stop events
  always_ff @(posedge I_LINK_CLK) begin
    if (link_rst) begin
      lrec_prev_r <= 1'b0;
      start_tgl_r <= 1'b0;
      stop_tgl_r  <= 1'b0;
    end else begin
      lrec_prev_r <= lrec_s;
      if (lrec_s && !lrec_prev_r) begin
        start_tgl_r <= ~start_tgl_r;
      end
      if (!lrec_s && lrec_prev_r) begin
        stop_tgl_r <= ~stop_tgl_r;
      end
    end
  end

  // Main domain synchronisers
  logic [8:0] pins_s;
  logic       wclk_s;
  logic       aes_s;
  logic       lin_s;
  logic       lout_s;
  logic       lwclk_s;
  logic       ltc_s;
  logic       lrxd_s;
  logic       start_tgl_s;
  logic       stop_tgl_s;

  bit_sync #(.WIDTH(9)) u_pin_sync (
    .i_clk (I_CLK),
    .i_rst (I_SRST),
    .i_d   ({I_WCLK, I_AES_FCLK, I_LINK_IN_CONN, I_LINK_OUT_CONN, I_LINK_WCLK,
             I_LINK_TC, I_LINK_RXD, start_tgl_r, stop_tgl_r}),
    .o_q   (pins_s)
  );

  assign {wclk_s, aes_s, lin_s, lout_s, lwclk_s, ltc_s, lrxd_s, start_tgl_s, stop_tgl_s} = pins_s;

  // Internal crystal-derived word clock
  logic [31:0] acc_r;
  logic [31:0] inc;

  always_comb begin
    case (I_RATE_SEL)
      `RATE_32K:    inc = `INC_32K;
      `RATE_44K1:   inc = `INC_44K1;
      `RATE_47K952: inc = `INC_47K952;
      `RATE_48K:    inc = `INC_48K;
      `RATE_48K048: inc = `INC_48K048;
      `RATE_88K2:   inc = `INC_88K2;
      `RATE_96K:    inc = `INC_96K;
      `RATE_96K096: inc = `INC_96K096;
      `RATE_176K4:  inc = `INC_176K4;
      `RATE_192K:   inc = `INC_192K;
      default:      inc = `INC_48K;
    endcase
  end

  // Free running so the clock keeps going with or without audio
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_r + inc;
    end
  end

  // Link roles
  logic slave;
  logic master;

  assign slave  = lin_s;
  assign master = lout_s && !lin_s;

  // External clock monitor
  wclk_pkg::clk_src_type mon_src;
  wclk_pkg::clk_src_type mon_src_r;
  logic                  mon_lvl;
  logic                  mon_prev_r;
  logic                  mon_rise;
  logic [CNT_W-1:0]      per_cnt_r;
  logic                  ext_good_r;
  logic                  rate_ok_r;

  assign mon_src = slave ? wclk_pkg::SRC_LINK : wclk_pkg::clk_src_type'(I_SRC_REQ);

  always_comb begin
    case (mon_src)
      wclk_pkg::SRC_WORD: mon_lvl = wclk_s;
      wclk_pkg::SRC_AES:  mon_lvl = aes_s;
      wclk_pkg::SRC_LINK: mon_lvl = lwclk_s;
      default:            mon_lvl = 1'b0;
    endcase
  end

  assign mon_rise = mon_lvl && !mon_prev_r;

  // Any edge spacing between the two limits is accepted, so off-speed rates record
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      mon_src_r  <= wclk_pkg::SRC_INT;
      mon_prev_r <= 1'b0;
      per_cnt_r  <= '0;
      ext_good_r <= 1'b0;
      rate_ok_r  <= 1'b0;
    end else begin
      mon_src_r  <= mon_src;
      mon_prev_r <= mon_lvl;
      if (mon_src != mon_src_r) begin
        per_cnt_r  <= '0;
        ext_good_r <= 1'b0;
        rate_ok_r  <= 1'b0;
      end else if (mon_rise) begin
        per_cnt_r  <= '0;
        rate_ok_r  <= (per_cnt_r >= PER_LO) && (per_cnt_r <= PER_HI);
        ext_good_r <= (per_cnt_r >= PER_LO) && (per_cnt_r <= PER_HI);
      end else if (per_cnt_r >= LOST_LIM) begin
        ext_good_r <= 1'b0;
        rate_ok_r  <= 1'b0;
      end else begin
        per_cnt_r <= per_cnt_r + 1'b1;
      end
    end
  end

  // Source choice
  wclk_pkg::clk_src_type target;
  wclk_pkg::clk_src_type cur_src_r;
  wclk_pkg::clk_src_type new_src_r;
  wclk_pkg::sw_state_type sw_state_r;
  logic                  rec_r;
  logic                  lost_hold_r;
  logic                  lost_evt;

  always_comb begin
    if (I_PLAY) begin
      target = wclk_pkg::SRC_INT;
    end else if (master) begin
      target = wclk_pkg::SRC_INT;
    end else if (lost_hold_r || !ext_good_r) begin
      target = wclk_pkg::SRC_INT;
    end else begin
      target = mon_src;
    end
  end

  // A clock that dies mid-file keeps the file at the internal rate until the take ends
  assign lost_evt = (cur_src_r != wclk_pkg::SRC_INT) && !ext_good_r;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      lost_hold_r <= 1'b0;
    end else if (lost_evt && rec_r) begin
      lost_hold_r <= 1'b1;
    end else if (!rec_r) begin
      lost_hold_r <= 1'b0;
    end
  end

  function automatic logic src_level(input wclk_pkg::clk_src_type s, input logic int_lvl,
                                     input logic w, input logic a, input logic l);
    case (s)
      wclk_pkg::SRC_WORD: src_level = w;
      wclk_pkg::SRC_AES:  src_level = a;
      wclk_pkg::SRC_LINK: src_level = l;
      default:            src_level = int_lvl;
    endcase
  endfunction

  logic cur_lvl;
  logic new_lvl;
  logic wclk_nxt;

  assign cur_lvl = src_level(cur_src_r, acc_r[31], wclk_s, aes_s, lwclk_s);
  assign new_lvl = src_level(new_src_r, acc_r[31], wclk_s, aes_s, lwclk_s);

  // Switch only through a low phase of both clocks, so no short pulse escapes
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      sw_state_r <= wclk_pkg::SW_RUN;
      cur_src_r  <= wclk_pkg::SRC_INT;
      new_src_r  <= wclk_pkg::SRC_INT;
    end else begin
      case (sw_state_r)
        wclk_pkg::SW_RUN: begin
          if (target != cur_src_r) begin
            new_src_r  <= target;
            sw_state_r <= wclk_pkg::SW_DRAIN;
          end
        end
        wclk_pkg::SW_DRAIN: begin
          // A dead source may be stuck high; its long high phase is no runt
          if (!cur_lvl || lost_evt) begin
            sw_state_r <= wclk_pkg::SW_ARM;
          end
        end
        wclk_pkg::SW_ARM: begin
          if (!new_lvl) begin
            cur_src_r  <= new_src_r;
            sw_state_r <= wclk_pkg::SW_RUN;
          end
        end
        default: begin
          sw_state_r <= wclk_pkg::SW_RUN;
        end
      endcase
    end
  end

  assign wclk_nxt = (sw_state_r == wclk_pkg::SW_ARM) ? 1'b0 : cur_lvl;

  // Same word clock goes to the local converters, the clock output and downstream
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_WCLK      <= 1'b0;
      O_LINK_WCLK <= 1'b0;
      O_CLK_SRC   <= wclk_pkg::SRC_INT;
    end else begin
      O_WCLK      <= wclk_nxt;
      O_LINK_WCLK <= wclk_nxt;
      O_CLK_SRC   <= cur_src_r;
    end
  end

  // Record control
  logic start_prev_r;
  logic stop_prev_r;
  logic link_start;
  logic link_stop;
  logic req_start;
  logic req_stop;
  logic pend_start_r;
  logic pend_stop_r;
  logic sample_edge;

  assign link_start  = slave && (start_tgl_s != start_prev_r);
  assign link_stop   = slave && (stop_tgl_s != stop_prev_r);
  // Local buttons on a slave act here and below only: nothing is sent upstream
  assign req_start   = I_REC_START || link_start;
  assign req_stop    = I_REC_STOP || link_stop;
  assign sample_edge = wclk_nxt && !O_WCLK;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      start_prev_r <= 1'b0;
      stop_prev_r  <= 1'b0;
    end else begin
      start_prev_r <= start_tgl_s;
      stop_prev_r  <= stop_tgl_s;
    end
  end

  // Requests are held until the next word clock rise; a new request on that cycle wins over the clear
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      pend_start_r <= 1'b0;
      pend_stop_r  <= 1'b0;
    end else begin
      if (req_stop) begin
        pend_stop_r  <= 1'b1;
        pend_start_r <= 1'b0;
      end else if (req_start) begin
        pend_start_r <= 1'b1;
        pend_stop_r  <= 1'b0;
      end else if (sample_edge) begin
        pend_start_r <= 1'b0;
        pend_stop_r  <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rec_r <= 1'b0;
    end else if (sample_edge && pend_stop_r) begin
      rec_r <= 1'b0;
    end else if (sample_edge && pend_start_r) begin
      rec_r <= 1'b1;
    end
  end

  // Downstream level moves ahead of the sample edge so the next unit hits the same sample
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_LINK_REC <= 1'b0;
    end else if (req_stop) begin
      O_LINK_REC <= 1'b0;
    end else if (req_start) begin
      O_LINK_REC <= 1'b1;
    end
  end

  // Time code and serial data repeat along the chain; no file naming travels
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_LINK_TC  <= 1'b0;
      O_LINK_TXD <= 1'b1;
      O_TC_RX    <= 1'b0;
      O_RXD      <= 1'b1;
    end else begin
      O_LINK_TC  <= slave ? ltc_s : I_TC;
      O_LINK_TXD <= slave ? lrxd_s : I_TXD;
      O_TC_RX    <= slave ? ltc_s : 1'b0;
      O_RXD      <= slave ? lrxd_s : 1'b1;
    end
  end

  // Status
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_EXT_LOST    <= 1'b0;
      O_RATE_OK     <= 1'b0;
      O_LINK_MASTER <= 1'b0;
      O_LINK_SLAVE  <= 1'b0;
      O_REC         <= 1'b0;
    end else begin
      O_EXT_LOST    <= lost_hold_r || lost_evt;
      O_RATE_OK     <= rate_ok_r;
      O_LINK_MASTER <= master;
      O_LINK_SLAVE  <= slave;
      O_REC         <= rec_r;
    end
  end

endmodule // wclk_link_ctrl

/* tb/wclk_link_ctrl_sva.sv */
`timescale 1ns/1ps

module wclk_link_ctrl_sva #(
  parameter int CNT_W    = 16,
  parameter int LOST_CYC = 5000,
  parameter int PER_MIN  = 260,
  parameter int PER_MAX  = 1563
) (
  // Clocks and reset
  input  wire logic       I_CLK,
  input  wire logic       I_SRST,
  input  wire logic       I_LINK_CLK,
  // Controls
  input  wire logic       I_PLAY,
  input  wire logic       I_REC_START,
  input  wire logic       I_REC_STOP,
  input  wire logic       I_LINK_IN_CONN,
  // Status
  input  wire logic       O_WCLK,
  input  wire logic [1:0] O_CLK_SRC,
  input  wire logic       O_EXT_LOST,
  input  wire logic       O_REC,
  input  wire logic       O_LINK_MASTER,
  input  wire logic       O_LINK_SLAVE,
  input  wire logic       O_LINK_WCLK,
  input  wire logic       O_LINK_REC
);
  localparam int SW_MAX = 1000;
  logic        wclk_q_r;
  logic [11:0] stall_r;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);

  // Cycles since the word clock last moved; a switch may hold it low for three half periods
  always_ff @(posedge I_CLK) begin
    wclk_q_r <= O_WCLK;
    if (I_SRST || O_WCLK != wclk_q_r) stall_r <= 12'h000;
    else if (stall_r != 12'hFFF) stall_r <= stall_r + 12'h001;
  end

  sequence s_on_int;
    ##[1:SW_MAX] O_CLK_SRC == wclk_pkg::SRC_INT;
  endsequence
  sequence s_wclk_edge;
    $past(O_WCLK) && !$past(O_WCLK, 2);
  endsequence

  property p_play_int;   $rose(I_PLAY) |-> s_on_int; endproperty
  property p_master_int; $rose(O_LINK_MASTER) |-> s_on_int; endproperty
  property p_lost_int;   $rose(O_EXT_LOST) |-> s_on_int; endproperty
  property p_wclk_runs;  stall_r < 12'h960; endproperty
  property p_link_wclk;  $rose(O_WCLK) |-> ##[0:1] O_LINK_WCLK; endproperty
  property p_start_down; I_REC_START && !I_REC_STOP |=> O_LINK_REC; endproperty
  property p_stop_down;  I_REC_STOP |=> !O_LINK_REC; endproperty
  property p_rec_sample; $changed(O_REC) |-> s_wclk_edge; endproperty
  property p_lost_keep;  O_EXT_LOST && O_REC && O_LINK_REC |=> O_EXT_LOST && O_REC; endproperty
  property p_roles;      !(O_LINK_MASTER && O_LINK_SLAVE); endproperty
  property p_slave_conn; $rose(I_LINK_IN_CONN) |-> ##[1:6] O_LINK_SLAVE; endproperty

  a_play_int:   assert property (p_play_int)   else $error("playback left external clock");
  a_master_int: assert property (p_master_int) else $error("master kept external clock");
  a_lost_int:   assert property (p_lost_int)   else $error("no fallback after loss");
  a_wclk_runs:  assert property (p_wclk_runs)  else $error("word clock stalled");
  a_link_wclk:  assert property (p_link_wclk)  else $error("link word clock not driven");
  a_start_down: assert property (p_start_down) else $error("start not sent downstream");
  a_stop_down:  assert property (p_stop_down)  else $error("stop not sent downstream");
  a_rec_sample: assert property (p_rec_sample) else $error("record change off sample edge");
  a_lost_keep:  assert property (p_lost_keep)  else $error("recording dropped on clock loss");
  a_roles:      assert property (p_roles)      else $error("both master and slave");
  a_slave_conn: assert property (p_slave_conn) else $error("slave role late");
endmodule // wclk_link_ctrl_sva

bind wclk_link_ctrl wclk_link_ctrl_sva #(
  .CNT_W(CNT_W), .LOST_CYC(LOST_CYC), .PER_MIN(PER_MIN), .PER_MAX(PER_MAX)
) u_sva (
  .I_CLK(I_CLK), .I_SRST(I_SRST), .I_LINK_CLK(I_LINK_CLK), .I_PLAY(I_PLAY),
  .I_REC_START(I_REC_START), .I_REC_STOP(I_REC_STOP), .I_LINK_IN_CONN(I_LINK_IN_CONN),
  .O_WCLK(O_WCLK), .O_CLK_SRC(O_CLK_SRC), .O_EXT_LOST(O_EXT_LOST), .O_REC(O_REC),
  .O_LINK_MASTER(O_LINK_MASTER), .O_LINK_SLAVE(O_LINK_SLAVE), .O_LINK_WCLK(O_LINK_WCLK),
  .O_LINK_REC(O_LINK_REC)
);

/* tb/wclk_far_model.sv */
`timescale 1ns/1ps

module wclk_far_model (
  // Bench controls
  input  wire logic i_wen,
  input  wire logic i_aen,
  input  wire logic i_len,
  input  wire logic i_rec,
  input  wire logic i_tc,
  input  wire logic i_rxd,
  // Pins toward the recorder
  output logic      o_wclk,
  output logic      o_aes,
  output logic      o_link_clk,
  output logic      o_link_wclk,
  output logic      o_link_rec,
  output logic      o_link_tc,
  output logic      o_link_rxd
);
  logic ck;

  // One shared reference keeps every source locked together
  initial begin
    ck = 1'b0;
    #5;
    forever #600 ck = ~ck;
  end
  initial begin
    o_link_clk = 1'b0;
    o_link_rec = 1'b0;
    #3;
    forever #7.5 o_link_clk = ~o_link_clk;
  end
  // A lost source is a flat line, as a pulled cable would be
  assign o_wclk      = i_wen & ck;
  assign o_aes       = i_aen & ck;
  assign o_link_wclk = i_len & ck;
  assign o_link_tc   = i_tc;
  assign o_link_rxd  = i_rxd;
  always @(posedge o_link_clk) o_link_rec <= i_rec;
endmodule // wclk_far_model

/* tb/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  logic       clk = 1'b0, srst = 1'b1, play = 1'b0, rs = 1'b0, rp = 1'b0, tc = 1'b0, txd = 1'b1;
  logic       inc = 1'b0, outc = 1'b0, wen = 1'b0, aen = 1'b0, len = 1'b0, prec = 1'b0, ptc = 1'b0, prxd = 1'b1;
  logic [3:0] rate = 4'h3;
  logic [1:0] req = 2'h0, o_src;
  logic       wclk, aes, lclk, lwclk, lrec, ltc, lrxd;
  logic       o_wclk, o_lost, o_ok, o_mst, o_slv, o_rec, o_tcrx, o_rxd, o_lwclk, o_lrec, o_ltc, o_ltxd;
  int         errors = 0, n_tests = 0, rises = 0, lrises = 0;
  realtime    t_now = 0, t_prev = 0;

  always #10 clk = ~clk;
  always @(posedge o_wclk) begin
    t_prev = t_now;
    t_now = $realtime;
    rises++;
  end
  always @(posedge o_lwclk) lrises++;

  // Loss timeout and period window shrunk so the run stays short
  wclk_link_ctrl #(.LOST_CYC(300), .PER_MIN(20), .PER_MAX(100)) DUT (
    .I_CLK(clk), .I_SRST(srst), .I_LINK_CLK(lclk), .I_RATE_SEL(rate), .I_SRC_REQ(req),
    .I_PLAY(play), .I_REC_START(rs), .I_REC_STOP(rp), .I_TC(tc), .I_TXD(txd),
    .I_WCLK(wclk), .I_AES_FCLK(aes), .I_LINK_IN_CONN(inc), .I_LINK_OUT_CONN(outc),
    .I_LINK_WCLK(lwclk), .I_LINK_REC(lrec), .I_LINK_TC(ltc), .I_LINK_RXD(lrxd),
    .O_WCLK(o_wclk), .O_CLK_SRC(o_src), .O_EXT_LOST(o_lost), .O_RATE_OK(o_ok),
    .O_LINK_MASTER(o_mst), .O_LINK_SLAVE(o_slv), .O_REC(o_rec), .O_TC_RX(o_tcrx), .O_RXD(o_rxd),
    .O_LINK_WCLK(o_lwclk), .O_LINK_REC(o_lrec), .O_LINK_TC(o_ltc), .O_LINK_TXD(o_ltxd)
  );
  wclk_far_model far (
    .i_wen(wen), .i_aen(aen), .i_len(len), .i_rec(prec), .i_tc(ptc), .i_rxd(prxd),
    .o_wclk(wclk), .o_aes(aes), .o_link_clk(lclk), .o_link_wclk(lwclk),
    .o_link_rec(lrec), .o_link_tc(ltc), .o_link_rxd(lrxd)
  );

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_src(input logic [1:0] s);
    for (int k = 0; k < 3000 && o_src !== s; k++) @(negedge clk);
  endtask
  task automatic wait_rec(input logic v);
    for (int k = 0; k < 2000 && o_rec !== v; k++) @(negedge clk);
  endtask
  task automatic start_rec;
    rs = 1'b1;
    cyc(1);
    rs = 1'b0;
    chk("downstream start", 16'(o_lrec), 16'h1);
  endtask
  task automatic stop_rec;
    rp = 1'b1;
    cyc(1);
    rp = 1'b0;
    chk("downstream stop", 16'(o_lrec), 16'h0);
  endtask

  task automatic t_master;
    int r0, l0, p;
    outc = 1'b1;
    req = 2'h1;
    wen = 1'b1;
    tc = 1'b1;
    txd = 1'b0;
    cyc(6);
    chk("master", 16'(o_mst), 16'h1);
    chk("link tc out", 16'(o_ltc), 16'h1);
    chk("link txd out", 16'(o_ltxd), 16'h0);
    r0 = rises;
    l0 = lrises;
    cyc(5208);
    chk("source", 16'(o_src), 16'h0);
    chk("internal rises", 16'((rises - r0 == 4) || (rises - r0 == 5)), 16'h1);
    chk("link rises", 16'((lrises - l0 == 4) || (lrises - l0 == 5)), 16'h1);
    // Each window spans two full periods at the new rate, so the last interval is clean
    rate = 4'h9;
    cyc(600);
    p = int'((t_now - t_prev) / 20.0);
    chk("192k period", 16'((p == 260) || (p == 261)), 16'h1);
    rate = 4'h0;
    cyc(3200);
    p = int'((t_now - t_prev) / 20.0);
    chk("32k period", 16'((p == 1562) || (p == 1563)), 16'h1);
    rate = 4'h3;
    outc = 1'b0;
    tc = 1'b0;
    txd = 1'b1;
    cyc(6);
  endtask

  task automatic t_ext;
    for (int s = 1; s < 3; s++) begin
      req = 2'(s);
      wen = (s == 1);
      aen = (s == 2);
      wait_src(2'(s));
      cyc(200);
      chk("source", 16'(o_src), 16'(s));
      chk("rate ok", 16'(o_ok), 16'h1);
      chk("period", 16'(int'((t_now - t_prev) / 20.0)), 16'h3C);
    end
    aen = 1'b0;
    cyc(1500);
    chk("fallback", 16'(o_src), 16'h0);
    chk("rate lost", 16'(o_ok), 16'h0);
  endtask

  task automatic t_play;
    req = 2'h1;
    wen = 1'b1;
    wait_src(2'h1);
    play = 1'b1;
    cyc(1200);
    chk("play source", 16'(o_src), 16'h0);
    play = 1'b0;
    wait_src(2'h1);
    chk("after play", 16'(o_src), 16'h1);
  endtask

  task automatic t_lost;
    start_rec;
    wait_rec(1'b1);
    chk("recording", 16'(o_rec), 16'h1);
    wen = 1'b0;
    cyc(1500);
    chk("lost", 16'(o_lost), 16'h1);
    chk("lost source", 16'(o_src), 16'h0);
    chk("still recording", 16'(o_rec), 16'h1);
    wen = 1'b1;
    cyc(600);
    chk("held internal", 16'(o_src), 16'h0);
    stop_rec;
    wait_rec(1'b0);
    chk("stopped", 16'(o_rec), 16'h0);
    wait_src(2'h1);
    chk("lost cleared", 16'(o_lost), 16'h0);
  endtask

  task automatic t_slave;
    inc = 1'b1;
    len = 1'b1;
    ptc = 1'b1;
    prxd = 1'b0;
    cyc(10);
    chk("slave", 16'(o_slv), 16'h1);
    chk("not master", 16'(o_mst), 16'h0);
    wait_src(wclk_pkg::SRC_LINK);
    chk("link source", 16'(o_src), 16'h3);
    chk("tc rx", 16'(o_tcrx), 16'h1);
    chk("rxd", 16'(o_rxd), 16'h0);
    chk("tc repeat", 16'(o_ltc), 16'h1);
    chk("txd repeat", 16'(o_ltxd), 16'h0);
    prec = 1'b1;
    wait_rec(1'b1);
    chk("follow start", 16'(o_lrec), 16'h1);
    stop_rec;
    wait_rec(1'b0);
    chk("local stop", 16'(o_rec), 16'h0);
    prec = 1'b0;
    cyc(100);
    inc = 1'b0;
    len = 1'b0;
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    cyc(4);
    srst = 1'b0;
    cyc(4);
    t_master;
    t_ext;
    t_play;
    t_lost;
    t_slave;
    close_out;
  end
  // Whole run is near 15k cycles; this leaves ample margin
  initial begin
    #1000000;
    errors++;
    close_out;
  end
endmodule // tb_top
